/* pkg/pad_gpio_consts.svh */
// register offsets, field positions, reset values and monitor codes of the pad block
`ifndef PAD_GPIO_CONSTS_SVH
`define PAD_GPIO_CONSTS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_PAD_OUTPUT_ENABLE 7'h44
`define ADDR_PAD_OUTPUT_VALUE 7'h45
`define ADDR_PAD_INPUT_VALUE 7'h46
`define ADDR_MONITOR_SIGNAL_SELECT 7'h47
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define FAST_IO_SWITCHING_BIT 7
`define MONITOR_CODE_MSB 3
`define CLOCK_OUTPUT_PIN_BIT 6
`define TEST_PIN_MSB 3
`define RST_PAD_OUTPUT_ENABLE 8'h00
`define RST_PAD_OUTPUT_VALUE 8'h00
`define RST_FAST_IO_SWITCHING 1'b0
`define RST_MONITOR_CODE 4'h0
`define RDATA_NONE 8'h00
// ----------------------------------------
// monitor source codes
// ----------------------------------------
`define MON_HIZ_A 4'h0
`define MON_HIZ_B 4'h1
`define MON_LOW 4'h2
`define MON_HIGH 4'h3
`define MON_TX_ENVELOPE 4'h4
`define MON_TX_ACTIVE 4'h5
`define MON_SECURE_LINK 4'h6
`define MON_RX_ENVELOPE 4'h7
`define MON_RX_ACTIVE 4'h8
`define MON_RX_BIT 4'h9
`endif

/* pkg/pad_gpio_pkg.sv */
// types shared by the pad block modules
package pad_gpio_pkg;
    typedef logic [7:0] pad_byte_t;
    typedef logic [6:0] reg_addr_t;
    typedef logic [3:0] monitor_code_t;
endpackage

/* pkg/pad_reg_if.sv */
// register port and register contents passed between core and register file
`timescale 1ns/1ps
interface pad_reg_if;
    logic wr;
    logic rd;
    pad_gpio_pkg::reg_addr_t addr;
    pad_gpio_pkg::pad_byte_t wdata;
    pad_gpio_pkg::pad_byte_t rdata;
    pad_gpio_pkg::pad_byte_t input_level;
    pad_gpio_pkg::pad_byte_t out_enable;
    pad_gpio_pkg::pad_byte_t out_value;
    logic fast_io;
    pad_gpio_pkg::monitor_code_t mon_code;
    modport regs (input wr, rd, addr, wdata, input_level,
                  output rdata, out_enable, out_value, fast_io, mon_code);
    modport core (output wr, rd, addr, wdata, input_level,
                  input rdata, out_enable, out_value, fast_io, mon_code);
endinterface

/* hdl/pad_regfile.sv */
// storage of three and read-back of all four pad configuration registers
`timescale 1ns/1ps
`include "pad_gpio_consts.svh"
module pad_regfile (
    input wire logic i_sys_clk, // system clock
    input wire logic i_rst_n, // async reset, active low
    pad_reg_if.regs bus // register port and contents
);
    pad_gpio_pkg::pad_byte_t enable_reg, enable_next;
    pad_gpio_pkg::pad_byte_t value_reg, value_next;
    logic speed_reg, speed_next;
    pad_gpio_pkg::monitor_code_t code_reg, code_next;
    pad_gpio_pkg::pad_byte_t rdata_reg, rdata_next;

    // ----------------------------------------
    // write decode and read mux
    // ----------------------------------------
    always_comb begin
        enable_next = enable_reg;
        value_next = value_reg;
        speed_next = speed_reg;
        code_next = code_reg;
        rdata_next = rdata_reg;
        if (bus.wr) begin
            unique case (bus.addr)
                `ADDR_PAD_OUTPUT_ENABLE: enable_next = bus.wdata;
                `ADDR_PAD_OUTPUT_VALUE: value_next = bus.wdata;
                `ADDR_MONITOR_SIGNAL_SELECT: begin
                    speed_next = bus.wdata[`FAST_IO_SWITCHING_BIT];
                    // reserved bits 6..4 are not stored
                    code_next = bus.wdata[`MONITOR_CODE_MSB:0];
                end
                default: ;
            endcase
        end
        if (bus.rd) begin
            unique case (bus.addr)
                `ADDR_PAD_OUTPUT_ENABLE: rdata_next = enable_reg;
                `ADDR_PAD_OUTPUT_VALUE: rdata_next = value_reg;
                `ADDR_PAD_INPUT_VALUE: rdata_next = bus.input_level;
                `ADDR_MONITOR_SIGNAL_SELECT: rdata_next = {speed_reg, 3'h0, code_reg};
                default: rdata_next = `RDATA_NONE;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            enable_reg <= `RST_PAD_OUTPUT_ENABLE;
            value_reg <= `RST_PAD_OUTPUT_VALUE;
            speed_reg <= `RST_FAST_IO_SWITCHING;
            code_reg <= `RST_MONITOR_CODE;
            rdata_reg <= `RDATA_NONE;
        end else begin
            enable_reg <= enable_next;
            value_reg <= value_next;
            speed_reg <= speed_next;
            code_reg <= code_next;
            rdata_reg <= rdata_next;
        end
    end

    assign bus.out_enable = enable_reg;
    assign bus.out_value = value_reg;
    assign bus.fast_io = speed_reg;
    assign bus.mon_code = code_reg;
    assign bus.rdata = rdata_reg;
endmodule // pad_regfile

/* hdl/pad_gpio_and_signal_monitor.sv */
// general purpose pad control and signal monitor output for eight spare pins
// Notes on behaviour
// - set enable bit drives matching pin out
// - clock pin enable stops clock output function
// - boundary scan masks enables of test pins
// - value register bits drive pin outputs
// - input register returns pin input levels
// - speed bit selects fast pad edges
// - codes 0-3 give tristate, low, high
// - codes 4-6 route transmitter side signals
// - codes 7-9 route receiver side signals
`timescale 1ns/1ps
`include "pad_gpio_consts.svh"
module pad_gpio_and_signal_monitor (
    input wire logic i_sys_clk, // system clock, 125 MHz
    input wire logic i_rst_n, // async reset, active low
    input wire logic i_reg_wr, // register write strobe
    input wire logic i_reg_rd, // register read strobe
    input wire logic [6:0] i_reg_addr, // register address
    input wire logic [7:0] i_reg_wdata, // register write data
    output logic [7:0] o_reg_rdata, // read data, one cycle after read
    input wire logic [7:0] i_pad_in, // pin input buffers
    output logic [7:0] o_pad_out, // pin output buffers
    output logic [7:0] o_pad_oe_n, // pin output enables, low drives
    input wire logic i_bscan_en, // boundary scan enabled in nonvolatile config
    output logic o_clock_output_pin_func_off, // clock output function switched off
    output logic o_fast_io, // pads in fast edge mode
    input wire logic i_tx_envelope, // transmitter envelope
    input wire logic i_tx_active, // transmitter active
    input wire logic i_secure_link, // generic secure link signal
    input wire logic i_rx_envelope, // receiver envelope
    input wire logic i_rx_active, // receiver active
    input wire logic i_rx_bit, // received bit stream
    output logic o_monitor_out, // monitor output pin level
    output logic o_monitor_oe_n // monitor output enable, low drives
);
    pad_reg_if rif();
    logic [8:0] sync1_reg, sync1_next;
    logic [8:0] sync2_reg, sync2_next;
    logic bscan_s;
    pad_gpio_pkg::pad_byte_t eff_en;
    pad_gpio_pkg::pad_byte_t pad_out_reg, pad_out_next;
    pad_gpio_pkg::pad_byte_t pad_oe_n_reg, pad_oe_n_next;
    logic clk_off_reg, clk_off_next;
    logic fast_reg, fast_next;
    logic mon_out_reg, mon_out_next;
    logic mon_oe_n_reg, mon_oe_n_next;

    // ----------------------------------------
    // register port
    // ----------------------------------------
    assign rif.wr = i_reg_wr;
    assign rif.rd = i_reg_rd;
    assign rif.addr = i_reg_addr;
    assign rif.wdata = i_reg_wdata;
    assign rif.input_level = sync2_reg[7:0];

    pad_regfile u_regs (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .bus(rif.regs)
    );

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    // scan strap is synced too: it may settle after reset release
    always_comb begin
        sync1_next = {i_bscan_en, i_pad_in};
        sync2_next = sync1_reg;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_reg <= 9'h000;
            sync2_reg <= 9'h000;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    assign bscan_s = sync2_reg[8];

    // ----------------------------------------
    // pad drivers
    // ----------------------------------------
    always_comb begin
        eff_en = rif.out_enable;
        if (bscan_s) begin
            eff_en[`TEST_PIN_MSB:0] = 4'h0;
        end
        pad_oe_n_next = ~eff_en;
        pad_out_next = rif.out_value;
        clk_off_next = eff_en[`CLOCK_OUTPUT_PIN_BIT];
        fast_next = rif.fast_io;
    end

    // ----------------------------------------
    // monitor selector
    // ----------------------------------------
    // reserved codes float the pin so a stray write cannot fight the board
    always_comb begin
        mon_out_next = 1'b0;
        mon_oe_n_next = 1'b0;
        unique case (rif.mon_code)
            `MON_HIZ_A, `MON_HIZ_B: mon_oe_n_next = 1'b1;
            `MON_LOW: mon_out_next = 1'b0;
            `MON_HIGH: mon_out_next = 1'b1;
            `MON_TX_ENVELOPE: mon_out_next = i_tx_envelope;
            `MON_TX_ACTIVE: mon_out_next = i_tx_active;
            `MON_SECURE_LINK: mon_out_next = i_secure_link;
            `MON_RX_ENVELOPE: mon_out_next = i_rx_envelope;
            `MON_RX_ACTIVE: mon_out_next = i_rx_active;
            `MON_RX_BIT: mon_out_next = i_rx_bit;
            default: mon_oe_n_next = 1'b1;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pad_out_reg <= 8'h00;
            pad_oe_n_reg <= 8'hFF;
            clk_off_reg <= 1'b0;
            fast_reg <= 1'b0;
            mon_out_reg <= 1'b0;
            mon_oe_n_reg <= 1'b1;
        end else begin
            pad_out_reg <= pad_out_next;
            pad_oe_n_reg <= pad_oe_n_next;
            clk_off_reg <= clk_off_next;
            fast_reg <= fast_next;
            mon_out_reg <= mon_out_next;
            mon_oe_n_reg <= mon_oe_n_next;
        end
    end

    assign o_pad_out = pad_out_reg;
    assign o_pad_oe_n = pad_oe_n_reg;
    assign o_clock_output_pin_func_off = clk_off_reg;
    assign o_fast_io = fast_reg;
    assign o_monitor_out = mon_out_reg;
    assign o_monitor_oe_n = mon_oe_n_reg;
    assign o_reg_rdata = rif.rdata;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    sequence en_write_s;
        i_reg_wr && i_reg_addr == `ADDR_PAD_OUTPUT_ENABLE;
    endsequence

    sequence out_write_s;
        i_reg_wr && i_reg_addr == `ADDR_PAD_OUTPUT_VALUE;
    endsequence

    sequence sel_write_s;
        i_reg_wr && i_reg_addr == `ADDR_MONITOR_SIGNAL_SELECT;
    endsequence

    enable_to_pin_a: assert property (en_write_s ##1 !i_reg_wr |=>
        o_pad_oe_n[7:4] == ~$past(i_reg_wdata[7:4], 2))
        else $error("pad enable write not seen on upper pins");
    clock_output_pin_off_a: assert property (o_clock_output_pin_func_off == !o_pad_oe_n[6])
        else $error("clock output function not tied to its enable");
    scan_mask_a: assert property (bscan_s |=> o_pad_oe_n[3:0] == 4'hF)
        else $error("test pins driven during boundary scan");
    value_to_pin_a: assert property (out_write_s ##1 !i_reg_wr |=>
        o_pad_out == $past(i_reg_wdata, 2))
        else $error("pad value write not seen on pins");
    input_read_a: assert property (i_reg_rd && i_reg_addr == `ADDR_PAD_INPUT_VALUE
        |=> o_reg_rdata == $past(sync2_reg[7:0]))
        else $error("input register read wrong level");
    sync_delay_a: assert property (sync2_reg[7:0] == $past(i_pad_in, 2))
        else $error("pin input not two flops late");
    speed_bit_a: assert property (sel_write_s ##1 !i_reg_wr |=>
        o_fast_io == $past(i_reg_wdata[7], 2))
        else $error("pad speed bit not applied");
    fixed_level_a: assert property (rif.mon_code == `MON_HIGH |=>
        !o_monitor_oe_n && o_monitor_out)
        else $error("monitor pin not driven high");
    monitor_hiz_a: assert property (rif.mon_code <= `MON_HIZ_B |=> o_monitor_oe_n)
        else $error("monitor pin driven for tristate code");
    tx_route_a: assert property (rif.mon_code == `MON_TX_ENVELOPE |=>
        o_monitor_out == $past(i_tx_envelope))
        else $error("transmitter envelope not routed");
    rx_route_a: assert property (rif.mon_code == `MON_RX_BIT |=>
        o_monitor_out == $past(i_rx_bit) && !o_monitor_oe_n)
        else $error("received bits not routed");
    idle_driver_a: assert property (!rif.out_enable[7] |=> o_pad_oe_n[7])
        else $error("pin driven with enable clear");
    test_pin_drive_a: assert property (!bscan_s && rif.out_enable[0] |=> !o_pad_oe_n[0])
        else $error("test pin not driven with enable set");
    clock_pin_drive_a: assert property (rif.out_enable[6] |=> !o_pad_oe_n[6] && o_clock_output_pin_func_off)
        else $error("clock pin not taken over by its enable");
    // read data must hold between reads: software may poll it late
    rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data changed without a read");

    // ----------------------------------------
    // monitor routing checks
    // ----------------------------------------
    low_level_a: assert property (rif.mon_code == `MON_LOW |=>
        !o_monitor_oe_n && !o_monitor_out)
        else $error("monitor pin not driven low");
    tx_active_a: assert property (rif.mon_code == `MON_TX_ACTIVE |=>
        o_monitor_out == $past(i_tx_active) && !o_monitor_oe_n)
        else $error("transmitter active not routed");
    secure_route_a: assert property (rif.mon_code == `MON_SECURE_LINK |=>
        o_monitor_out == $past(i_secure_link) && !o_monitor_oe_n)
        else $error("secure link signal not routed");
    rx_env_route_a: assert property (rif.mon_code == `MON_RX_ENVELOPE |=>
        o_monitor_out == $past(i_rx_envelope) && !o_monitor_oe_n)
        else $error("receiver envelope not routed");
    rx_active_a: assert property (rif.mon_code == `MON_RX_ACTIVE |=>
        o_monitor_out == $past(i_rx_active) && !o_monitor_oe_n)
        else $error("receiver active not routed");
endmodule // pad_gpio_and_signal_monitor

/* sim/pad_board_model.sv */
// board logic on the eight spare pins, resolving each wire against the device
`timescale 1ns/1ps
module pad_board_model (
    input wire logic [7:0] i_pad_out, // device output values
    input wire logic [7:0] i_pad_oe_n, // device enables, low drives
    input wire logic [7:0] i_board_level, // level the board puts on free pins
    output logic [7:0] o_pin_level // resolved wire level seen by the pad inputs
);
    // the device wins where it drives; a free pin shows only the board level
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            o_pin_level[i] = (i_pad_oe_n[i] === 1'b0) ? i_pad_out[i] : i_board_level[i];
        end
    end
endmodule // pad_board_model

/* sim/tb.sv */
// self-checking bench for the pad control and monitor block
`timescale 1ns/1ps
`include "pad_gpio_consts.svh"
module tb;
    logic i_sys_clk, i_rst_n, i_reg_wr, i_reg_rd, i_bscan_en;
    logic [6:0] i_reg_addr;
    pad_gpio_pkg::pad_byte_t i_reg_wdata, o_reg_rdata, i_pad_in, o_pad_out, o_pad_oe_n;
    pad_gpio_pkg::pad_byte_t board, en, val;
    logic o_clock_output_pin_func_off, o_fast_io, o_monitor_out, o_monitor_oe_n;
    logic [5:0] src; // tx env, tx act, secure link, rx env, rx act, rx bit
    logic [7:0] exp_q[$];
    int error_cnt = 0;
    int checks_done = 0;
    integer seed = 32'hc681_90fe;

    pad_gpio_and_signal_monitor u_pad_gpio_and_signal_monitor (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_pad_in(i_pad_in), .o_pad_out(o_pad_out), .o_pad_oe_n(o_pad_oe_n),
        .i_bscan_en(i_bscan_en), .o_clock_output_pin_func_off(o_clock_output_pin_func_off), .o_fast_io(o_fast_io),
        .i_tx_envelope(src[0]), .i_tx_active(src[1]), .i_secure_link(src[2]),
        .i_rx_envelope(src[3]), .i_rx_active(src[4]), .i_rx_bit(src[5]),
        .o_monitor_out(o_monitor_out), .o_monitor_oe_n(o_monitor_oe_n));
    pad_board_model u_pad_board_model (.i_pad_out(o_pad_out), .i_pad_oe_n(o_pad_oe_n),
        .i_board_level(board), .o_pin_level(i_pad_in));

    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // returns a little after the second edge past the write edge, pins settled
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_sys_clk);
        i_reg_wr <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        #1;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge i_sys_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        exp_q.push_back(e);
        @(posedge i_sys_clk);
        i_reg_rd <= 1'b0;
    endtask

    // read data lands just after the edge that takes the strobe
    always @(posedge i_sys_clk) begin
        if (i_reg_rd === 1'b1) begin
            #1;
            if (exp_q.size() == 0) begin
                chk("read queue", 8'h01, 8'h00);
            end else begin
                chk("read data", exp_q.pop_front(), o_reg_rdata);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge i_sys_clk);
        error_cnt++;
        close_out;
    end

    initial begin
        {i_rst_n, i_reg_wr, i_reg_rd, i_bscan_en} = 4'h0;
        i_reg_addr = 7'h00;
        i_reg_wdata = 8'h00;
        board = 8'h00;
        src = 6'h00;
        repeat (12) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        #1;
        chk("oe_n", 8'hFF, o_pad_oe_n);
        chk("monitor idle", 8'h02, {6'h00, o_monitor_oe_n, o_monitor_out});
        chk("pad flags idle", 8'h00, {6'h00, o_fast_io, o_clock_output_pin_func_off});
        chk("pad out idle", 8'h00, o_pad_out);
        chk("rdata idle", 8'h00, o_reg_rdata);
        rd(`ADDR_PAD_OUTPUT_ENABLE, 8'h00);
        rd(`ADDR_MONITOR_SIGNAL_SELECT, 8'h00);
        rd(7'h48, 8'h00);
        $display("test reset done");
        // old, old, new: the input crosses two flops before it can be read
        @(posedge i_sys_clk);
        board <= 8'hA5;
        i_reg_rd <= 1'b1;
        i_reg_addr <= `ADDR_PAD_INPUT_VALUE;
        exp_q.push_back(8'h00);
        exp_q.push_back(8'h00);
        exp_q.push_back(8'hA5);
        repeat (3) @(posedge i_sys_clk);
        i_reg_rd <= 1'b0;
        $display("test input sync done");
        for (int n = 0; n < 8; n++) begin
            en = 8'($random(seed));
            val = 8'($random(seed));
            board <= 8'($random(seed));
            wr(`ADDR_PAD_OUTPUT_ENABLE, en);
            wr(`ADDR_PAD_OUTPUT_VALUE, val);
            chk("oe_n", ~en, o_pad_oe_n);
            chk("pad out", val, o_pad_out);
            chk("clock_output_pin off", {7'h00, en[6]}, {7'h00, o_clock_output_pin_func_off});
            wr(`ADDR_PAD_INPUT_VALUE, ~en);
            rd(`ADDR_PAD_OUTPUT_ENABLE, en);
            rd(`ADDR_PAD_OUTPUT_VALUE, val);
            rd(`ADDR_PAD_INPUT_VALUE, (val & en) | (board & ~en));
        end
        $display("test pad enables done");
        i_bscan_en <= 1'b1;
        wr(`ADDR_PAD_OUTPUT_ENABLE, 8'hFF);
        repeat (3) @(posedge i_sys_clk);
        #1;
        chk("oe_n scan", 8'h0F, o_pad_oe_n);
        rd(`ADDR_PAD_OUTPUT_ENABLE, 8'hFF);
        i_bscan_en <= 1'b0;
        repeat (5) @(posedge i_sys_clk);
        #1;
        chk("oe_n no scan", 8'h00, o_pad_oe_n);
        $display("test boundary scan done");
        // reserved codes and bits 6..4 are never written
        for (int c = 0; c < 10; c++) begin
            wr(`ADDR_MONITOR_SIGNAL_SELECT, {c[0], 3'h0, c[3:0]});
            chk("fast io", {7'h00, c[0]}, {7'h00, o_fast_io});
            rd(`ADDR_MONITOR_SIGNAL_SELECT, {c[0], 3'h0, c[3:0]});
            repeat (4) begin
                @(posedge i_sys_clk);
                src <= 6'($random(seed));
                @(posedge i_sys_clk);
                #1;
                chk("monitor oe_n", {7'h00, c < 2}, {7'h00, o_monitor_oe_n});
                if (c >= 2) begin
                    chk("monitor", {7'h00, (c == 3) | (c > 3 && src[c - 4])}, {7'h00, o_monitor_out});
                end
            end
        end
        $display("test monitor done");
        repeat (3) @(posedge i_sys_clk);
        close_out;
    end
endmodule // tb
